/* pkg/cfo_consts.svh */
`ifndef CFO_CONSTS_SVH
`define CFO_CONSTS_SVH
// Width of shift and control registers
`define CFO_CTRL_W 11
// Number of fan-out channels
`define CFO_OUT_N 10
// Position of the source select bit
`define CFO_SEL_BIT 10
// Shift count at which the eleventh bit lands
`define CFO_LAST_CNT 4'ha
// Reset values
`define CFO_SHIFT_RST 11'h000
`define CFO_CTRL_RST 11'h000
`define CFO_CNT_RST 4'h0
`define CFO_ON_RST 10'h000
// Every channel on
`define CFO_ALL_ON 10'h3ff
`endif

/* pkg/cfo_pkg.sv */
`include "cfo_consts.svh"
package cfo_pkg;
    // Load sequencer states
    typedef enum logic [1:0] {
        cfo_st_shift,
        cfo_st_full,
        cfo_st_done
    } cfo_fsm_t;
    // State on the configuration clock
    typedef struct packed {
        logic [`CFO_CTRL_W-1:0] shreg;
        logic [3:0] cnt;
        cfo_fsm_t fsm;
        logic [`CFO_CTRL_W-1:0] ctrl;
        logic comm;
        logic tog;
    } cfo_link_t;
    // State on the system clock
    typedef struct packed {
        logic en_s1;
        logic en_s2;
        logic si_s1;
        logic si_s2;
        logic c0_s1;
        logic c0_s2;
        logic c1_s1;
        logic c1_s2;
        logic tg_s1;
        logic tg_s2;
        logic tg_seen;
        logic [`CFO_CTRL_W-1:0] ctrl_c;
        logic comm_c;
        logic [`CFO_OUT_N-1:0] on;
        logic sel;
        logic [`CFO_OUT_N-1:0] q_t;
        logic [`CFO_OUT_N-1:0] q_c;
    } cfo_core_t;
endpackage

/* design/cfo_serial_config.sv */
`timescale 1ns/100ps
`include "cfo_consts.svh"
module cfo_serial_config (
    input wire logic clk_i, // System clock, 250 MHz
    input wire logic sys_rst_i, // Async reset, active high
    input wire logic ce_i, // Clock enable for system domain
    input wire logic config_shift_clock_i, // Configuration clock
    input wire logic program_enable_i, // High selects programmed mode
    input wire logic serial_in_i, // Serial data or source select
    input wire logic clock_input_zero_i, // Clock source 0
    input wire logic clock_input_one_i, // Clock source 1
    output logic [`CFO_OUT_N-1:0] fanout_output_n_o, // True outputs
    output logic [`CFO_OUT_N-1:0] fanout_output_n_bar_o, // Complement outputs
    output logic [`CFO_OUT_N-1:0] out_on_o, // Channel powered on
    output logic cfg_loaded_o // A load has been committed
);
    import cfo_pkg::*;

    // Serial bit order into control bit order
    function automatic logic [`CFO_CTRL_W-1:0] cfo_rev11(input logic [`CFO_CTRL_W-1:0] v);
        logic [`CFO_CTRL_W-1:0] r;
        r = '0;
        for (int i = 0; i < `CFO_CTRL_W; i++) begin
            r[i] = v[`CFO_CTRL_W-1-i];
        end
        return r;
    endfunction

    // Control bit k enables channel 9-k
    function automatic logic [`CFO_OUT_N-1:0] cfo_rev10(input logic [`CFO_OUT_N-1:0] v);
        logic [`CFO_OUT_N-1:0] r;
        r = '0;
        for (int i = 0; i < `CFO_OUT_N; i++) begin
            r[i] = v[`CFO_OUT_N-1-i];
        end
        return r;
    endfunction

    cfo_link_t lk_reg; // Configuration clock state
    cfo_link_t lk_next; // Its next value
    cfo_core_t co_reg; // System clock state
    cfo_core_t co_next; // Its next value

    // Load sequencer on the configuration clock.
    // Enable and serial data meet setup and hold to this
    // clock, so they are sampled here without synchronisers.
    always_comb begin
        lk_next = lk_reg;
        if (!program_enable_i) begin
            // Pulse in standard mode clears the whole loader
            lk_next.shreg = `CFO_SHIFT_RST;
            lk_next.cnt = `CFO_CNT_RST;
            lk_next.fsm = cfo_st_shift;
            lk_next.ctrl = `CFO_CTRL_RST;
            lk_next.comm = 1'b0;
            // Toggle so the system side sees the cleared word
            lk_next.tog = ~lk_reg.tog;
        end else begin
            case (lk_reg.fsm)
                cfo_st_shift: begin
                    // First stage takes the line, rest move up
                    lk_next.shreg = {lk_reg.shreg[`CFO_CTRL_W-2:0], serial_in_i};
                    lk_next.cnt = lk_reg.cnt + 4'h1;
                    if (lk_reg.cnt == `CFO_LAST_CNT) begin
                        lk_next.fsm = cfo_st_full;
                    end
                end
                cfo_st_full: begin
                    // Twelfth pulse commits the word
                    lk_next.ctrl = cfo_rev11(lk_reg.shreg);
                    lk_next.comm = 1'b1;
                    lk_next.tog = ~lk_reg.tog;
                    lk_next.fsm = cfo_st_done;
                end
                cfo_st_done: begin
                    // Further pulses ignored until a reset pulse
                    lk_next = lk_reg;
                end
                default: begin
                    lk_next.fsm = cfo_st_shift;
                end
            endcase
        end
    end

    // Configuration clock register.
    // This clock may stop between loads, so nothing here
    // waits on a later edge; the toggle carries each change.
    // Reset leaves without a synchroniser; the controller
    // keeps this clock idle around a reset, so no recovery race.
    always_ff @(posedge config_shift_clock_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            lk_reg <= '{shreg: `CFO_SHIFT_RST, cnt: `CFO_CNT_RST, fsm: cfo_st_shift,
                        ctrl: `CFO_CTRL_RST, comm: 1'b0, tog: 1'b0};
        end else begin
            lk_reg <= lk_next;
        end
    end

    // System side: synchronise pins, take the word, drive outputs
    always_comb begin
        logic [`CFO_OUT_N-1:0] on_v;
        logic sel_v;
        logic clk_v;
        on_v = '0;
        sel_v = 1'b0;
        clk_v = 1'b0;
        co_next = co_reg;
        // Two-stage synchronisers for every outside level
        co_next.en_s1 = program_enable_i;
        co_next.en_s2 = co_reg.en_s1;
        co_next.si_s1 = serial_in_i;
        co_next.si_s2 = co_reg.si_s1;
        co_next.c0_s1 = clock_input_zero_i;
        co_next.c0_s2 = co_reg.c0_s1;
        co_next.c1_s1 = clock_input_one_i;
        co_next.c1_s2 = co_reg.c1_s1;
        co_next.tg_s1 = lk_reg.tog;
        co_next.tg_s2 = co_reg.tg_s1;
        // The word itself is not synchronised: it only
        // changes on the config edge that flips the toggle,
        // and the toggle needs two flops to get here.
        // Limitation: keep the controller idle while ce_i is
        // low; an even number of updates in that time cancel
        // out in the toggle and the old word would stay.
        // Word is stable two edges before the toggle arrives
        if (co_reg.tg_s2 != co_reg.tg_seen) begin
            co_next.tg_seen = co_reg.tg_s2;
            co_next.ctrl_c = lk_reg.ctrl;
            co_next.comm_c = lk_reg.comm;
        end
        if (!co_reg.en_s2) begin
            // Standard mode: all on, line picks the source
            on_v = `CFO_ALL_ON;
            sel_v = co_reg.si_s2;
        end else if (co_reg.comm_c) begin
            // Programmed mode with a committed word
            on_v = cfo_rev10(co_reg.ctrl_c[`CFO_OUT_N-1:0]);
            sel_v = co_reg.ctrl_c[`CFO_SEL_BIT];
        end else begin
            // Nothing committed yet: cleared register
            on_v = `CFO_ON_RST;
            sel_v = 1'b0;
        end
        clk_v = sel_v ? co_reg.c1_s2 : co_reg.c0_s2;
        co_next.on = on_v;
        co_next.sel = sel_v;
        // Powered-off channel drives both legs low
        co_next.q_t = on_v & {`CFO_OUT_N{clk_v}};
        co_next.q_c = on_v & {`CFO_OUT_N{~clk_v}};
    end

    // System clock register, frozen while the enable is low
    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            co_reg <= '0;
        end else if (ce_i) begin
            co_reg <= co_next;
        end
    end

    // Outputs straight from flops
    // Complement leg is a flop of its own, so an off channel
    // can hold both legs low instead of a false differential.
    assign fanout_output_n_o = co_reg.q_t;
    assign fanout_output_n_bar_o = co_reg.q_c;
    assign out_on_o = co_reg.on;
    assign cfg_loaded_o = co_reg.comm_c;

    // Checks on the configuration clock
    // These run only while the link clock pulses; a stopped
    // clock leaves them idle rather than failing.
    property p_shift;
        @(posedge config_shift_clock_i) disable iff (sys_rst_i)
        program_enable_i && lk_reg.fsm == cfo_st_shift |=>
            lk_reg.shreg == {$past(lk_reg.shreg[`CFO_CTRL_W-2:0]), $past(serial_in_i)};
    endproperty
    a_shift: assert property (p_shift) else $error("shift stage mismatch");

    property p_eleven;
        @(posedge config_shift_clock_i) disable iff (sys_rst_i)
        program_enable_i && lk_reg.fsm == cfo_st_shift && lk_reg.cnt == `CFO_LAST_CNT
            |=> lk_reg.fsm == cfo_st_full && !lk_reg.comm;
    endproperty
    a_eleven: assert property (p_eleven) else $error("eleventh bit not full");

    property p_commit;
        @(posedge config_shift_clock_i) disable iff (sys_rst_i)
        program_enable_i && lk_reg.fsm == cfo_st_full |=>
            lk_reg.comm && lk_reg.ctrl == cfo_rev11($past(lk_reg.shreg));
    endproperty
    a_commit: assert property (p_commit) else $error("commit word wrong");

    property p_reset;
        @(posedge config_shift_clock_i) disable iff (sys_rst_i)
        !program_enable_i |=> lk_reg.ctrl == `CFO_CTRL_RST && lk_reg.shreg == `CFO_SHIFT_RST
            && !lk_reg.comm && lk_reg.fsm == cfo_st_shift;
    endproperty
    a_reset: assert property (p_reset) else $error("reset pulse missed");

    property p_once;
        @(posedge config_shift_clock_i) disable iff (sys_rst_i)
        program_enable_i && lk_reg.fsm == cfo_st_done |=> $stable(lk_reg.ctrl) && lk_reg.comm;
    endproperty
    a_once: assert property (p_once) else $error("second load accepted");

    // Bit counter never runs past the commit point
    property p_cnt_cap;
        @(posedge config_shift_clock_i) disable iff (sys_rst_i)
        lk_reg.cnt <= `CFO_LAST_CNT + 4'h1;
    endproperty
    a_cnt_cap: assert property (p_cnt_cap) else $error("shift count overran");

    // A loaded sequencer keeps its shifter untouched as well
    property p_done_hold;
        @(posedge config_shift_clock_i) disable iff (sys_rst_i)
        program_enable_i && lk_reg.fsm == cfo_st_done |=>
            lk_reg.fsm == cfo_st_done && $stable(lk_reg.shreg);
    endproperty
    a_done_hold: assert property (p_done_hold) else $error("loaded shifter moved");

    // Checks on the system clock
    // One register stage sits between cause and effect
    property p_std_on;
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && !co_reg.en_s2 |=> co_reg.on == `CFO_ALL_ON;
    endproperty
    a_std_on: assert property (p_std_on) else $error("standard mode channel off");

    property p_std_sel;
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && !co_reg.en_s2 |=> co_reg.sel == $past(co_reg.si_s2);
    endproperty
    a_std_sel: assert property (p_std_sel) else $error("standard select wrong");

    property p_decode;
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && co_reg.en_s2 && co_reg.comm_c |=>
            co_reg.on == cfo_rev10($past(co_reg.ctrl_c[`CFO_OUT_N-1:0]))
            && co_reg.sel == $past(co_reg.ctrl_c[`CFO_SEL_BIT]);
    endproperty
    a_decode: assert property (p_decode) else $error("control decode wrong");

    property p_legs;
        @(posedge clk_i) disable iff (sys_rst_i)
        (co_reg.q_t ^ co_reg.q_c) == co_reg.on;
    endproperty
    a_legs: assert property (p_legs) else $error("output legs inconsistent");

    property p_follow;
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i ##1 co_reg.on[0] |-> co_reg.q_t[0] == (co_reg.sel ? $past(co_reg.c1_s2) : $past(co_reg.c0_s2));
    endproperty
    a_follow: assert property (p_follow) else $error("output inverted");

    property p_clear;
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && co_reg.en_s2 && !co_reg.comm_c |=> co_reg.on == `CFO_ON_RST;
    endproperty
    a_clear: assert property (p_clear) else $error("uncommitted channel on");

    // Off channels hold both legs low
    property p_off_low;
        @(posedge clk_i) disable iff (sys_rst_i)
        ((co_reg.q_t | co_reg.q_c) & ~co_reg.on) == `CFO_ON_RST;
    endproperty
    a_off_low: assert property (p_off_low) else $error("off channel driving");

    // Word and flag are taken together when the toggle lands
    property p_capture;
        @(posedge clk_i) disable iff (sys_rst_i)
        ce_i && co_reg.tg_s2 != co_reg.tg_seen |=>
            co_reg.ctrl_c == $past(lk_reg.ctrl) && co_reg.comm_c == $past(lk_reg.comm);
    endproperty
    a_capture: assert property (p_capture) else $error("committed word not taken");

    // No committed flag means a cleared word
    property p_cleared;
        @(posedge clk_i) disable iff (sys_rst_i)
        !co_reg.comm_c |-> co_reg.ctrl_c == `CFO_CTRL_RST;
    endproperty
    a_cleared: assert property (p_cleared) else $error("stale word without commit");

    // Main scenarios
    c_commit: cover property (@(posedge config_shift_clock_i) disable iff (sys_rst_i)
        lk_reg.fsm == cfo_st_full ##1 lk_reg.fsm == cfo_st_done);
    c_reload: cover property (@(posedge config_shift_clock_i) disable iff (sys_rst_i)
        lk_reg.fsm == cfo_st_done && !program_enable_i);
    c_prog_on: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        co_reg.en_s2 && co_reg.comm_c && co_reg.on != `CFO_ON_RST);
    c_std_one: cover property (@(posedge clk_i) disable iff (sys_rst_i)
        !co_reg.en_s2 && co_reg.sel);
    c_partial: cover property (@(posedge config_shift_clock_i) disable iff (sys_rst_i)
        lk_reg.fsm == cfo_st_shift && lk_reg.cnt != `CFO_CNT_RST && !program_enable_i);
endmodule

/* dv/cfo_ctrl_model.sv */
`timescale 1ns/100ps
// Outside controller: configuration clock, enable and serial line
module cfo_ctrl_model (
    output logic cfg_clk_o, // Configuration clock, idle low
    output logic prog_en_o, // High selects programmed mode
    output logic sdata_o // Serial data or source select
);
    localparam real HALF_NS = 24.0; // Half of the 48 ns link period
    // Clock stands still between frames
    initial begin
        cfg_clk_o = 1'b0;
        prog_en_o = 1'b0;
        sdata_o = 1'b0;
    end
    // One pulse; data leads the edge by half a period for setup
    task automatic pulse(input logic b);
        sdata_o = b;
        #(HALF_NS) cfg_clk_o = 1'b1;
        #(HALF_NS) cfg_clk_o = 1'b0;
    endtask
    // Static mode and serial level, no clock
    task automatic set_level(input logic en, input logic b);
        prog_en_o = en;
        sdata_o = b;
        #(HALF_NS);
    endtask
    // Pulse with enable low clears the load sequencer
    task automatic reset_pulse();
        set_level(1'b0, 1'b0);
        pulse(1'b0);
    endtask
    // Word bit 0 goes first, then an optional commit pulse
    task automatic load(input logic [10:0] w, input int nbits, input logic commit);
        set_level(1'b1, w[0]);
        for (int i = 0; i < nbits; i++) begin
            pulse(w[i]);
        end
        // Commit data is a don't care; inverted so it cannot pass as a bit
        if (commit) begin
            pulse(~w[10]);
        end
    endtask
endmodule

/* dv/clock_fanout_serial_config_tb_top.sv */
`timescale 1ns/100ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected at %0t ns: got %h want %h", $time, got, exp); end end
module clock_fanout_serial_config_tb_top;
    logic clk; // System clock
    logic sys_rst; // Async reset
    logic c0; // Clock source 0, slow level
    logic c1; // Clock source 1, slow level
    logic cfg_clk; // Link clock from controller
    logic en; // Mode level from controller
    logic sdi; // Serial line from controller
    logic [9:0] q_t; // True legs
    logic [9:0] q_c; // Complement legs
    logic [9:0] on; // Channel power
    logic loaded; // Committed flag
    logic ce; // System clock enable
    logic [9:0] frz_on; // Channels expected while frozen
    int n_errors = 0; // Mismatch count
    int tests_run = 0; // Comparison count
    localparam logic [10:0] W_A = 11'h4b5; // Source one, mixed enables
    localparam logic [10:0] W_B = 11'h2d3; // Source zero, other mix
    cfo_serial_config cfo_serial_config_inst (
        .clk_i(clk),
        .sys_rst_i(sys_rst),
        .ce_i(ce),
        .config_shift_clock_i(cfg_clk),
        .program_enable_i(en),
        .serial_in_i(sdi),
        .clock_input_zero_i(c0),
        .clock_input_one_i(c1),
        .fanout_output_n_o(q_t),
        .fanout_output_n_bar_o(q_c),
        .out_on_o(on),
        .cfg_loaded_o(loaded)
    );
    cfo_ctrl_model cfo_ctrl_model_inst (
        .cfg_clk_o(cfg_clk),
        .prog_en_o(en),
        .sdata_o(sdi)
    );
    // Free running 250 MHz clock
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // Verdict and end of run
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Both source phases; expected channels worked out from the word
    task automatic expect_out(input logic [10:0] ctrl, input logic std, input logic ld);
        logic [9:0] on_x;
        logic src;
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            #1;
            c0 = p[0];
            c1 = ~p[0];
            // Generous wait covers sync plus register latency
            repeat (10) @(posedge clk);
            #1;
            for (int k = 0; k < 10; k++) begin
                on_x[k] = std | ctrl[9-k];
            end
            src = (std ? sdi : ctrl[10]) ? c1 : c0;
            `CHK(on, on_x)
            `CHK(q_t, on_x & {10{src}})
            `CHK(q_c, on_x & {10{~src}})
            `CHK(loaded, ld)
        end
    endtask
    // Progress line per test
    task automatic end_test(input string name);
        $display("test %s done, mismatches so far %0d", name, n_errors);
    endtask
    // Hang guard, far beyond the few microseconds the tests need
    initial begin
        #50000;
        n_errors++;
        $display("unexpected at %0t ns: watchdog expired", $time);
        close_out();
    end
    // Main sequence
    initial begin
        sys_rst = 1'b1;
        ce = 1'b1;
        c0 = 1'b0;
        c1 = 1'b0;
        repeat (4) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        // Standard mode at both select levels
        for (int s = 0; s < 2; s++) begin
            cfo_ctrl_model_inst.set_level(1'b0, s[0]);
            expect_out(11'h000, 1'b1, 1'b0);
        end
        end_test("standard");
        cfo_ctrl_model_inst.set_level(1'b1, 1'b0);
        expect_out(11'h000, 1'b0, 1'b0);
        cfo_ctrl_model_inst.load(W_A, 11, 1'b0);
        expect_out(11'h000, 1'b0, 1'b0);
        cfo_ctrl_model_inst.pulse(1'b0);
        expect_out(W_A, 1'b0, 1'b1);
        end_test("load");
        // Second word without a reset pulse is refused
        cfo_ctrl_model_inst.load(W_B, 11, 1'b1);
        expect_out(W_A, 1'b0, 1'b1);
        cfo_ctrl_model_inst.set_level(1'b0, 1'b1);
        expect_out(11'h000, 1'b1, 1'b1);
        cfo_ctrl_model_inst.set_level(1'b1, 1'b0);
        expect_out(W_A, 1'b0, 1'b1);
        end_test("override");
        cfo_ctrl_model_inst.reset_pulse();
        expect_out(11'h000, 1'b1, 1'b0);
        cfo_ctrl_model_inst.set_level(1'b1, 1'b0);
        expect_out(11'h000, 1'b0, 1'b0);
        // Partial word dropped by a reset pulse, then a fresh load
        cfo_ctrl_model_inst.load(W_B, 5, 1'b0);
        cfo_ctrl_model_inst.reset_pulse();
        cfo_ctrl_model_inst.load(W_B, 11, 1'b1);
        expect_out(W_B, 1'b0, 1'b1);
        end_test("reload");
        // Clock enable low holds every output; source was high when frozen
        for (int k = 0; k < 10; k++) begin
            frz_on[k] = W_B[9-k];
        end
        @(posedge clk);
        #1;
        ce = 1'b0;
        c0 = ~c0;
        repeat (10) @(posedge clk);
        #1;
        `CHK(on, frz_on)
        `CHK(q_t, frz_on)
        `CHK(q_c, 10'h000)
        ce = 1'b1;
        expect_out(W_B, 1'b0, 1'b1);
        end_test("freeze");
        close_out();
    end
endmodule
